// ===== design/lddc_consts.svh
// constants of the led dimming controller: offsets, resets, codes, times
// assumes a single 50 ns system clock; included by name from the package
`ifndef LDDC_CONSTS_SVH
`define LDDC_CONSTS_SVH
`define LDDC_OFS_DUTY 8'h00
`define LDDC_OFS_CTRL 8'h01
`define LDDC_OFS_DCS 8'h07
`define LDDC_RST_DUTY 8'hFF
`define LDDC_RST_CTRL 8'h01
`define LDDC_RST_DCS 8'hFF
`define LDDC_RST_READ 8'h00
`define LDDC_CTRL_PROD 8'h01
`define LDDC_CTRL_EXT 8'h03
`define LDDC_CTRL_REG 8'h05
`define LDDC_STEPS 255
`define LDDC_CLK_NS 50
`define LDDC_EN_LOW_NS 30000000
`define LDDC_PWM_LOW_NS 30500000
// serial slave address, arbitrary value
`define LDDC_DEV_ADDR 7'h2C
`endif

// ===== design/lddc_pkg.sv
// types shared by the led dimming controller modules
// assumes lddc_consts.svh is on the include path
`include "lddc_consts.svh"
package lddc_pkg;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_AACK = 7'h04,
      S_WBYTE = 7'h08,
      S_WACK = 7'h10,
      S_RBYTE = 7'h20,
      S_RACK = 7'h40
   } lddc_bus_st_t;
   typedef enum logic [3:0] {
      M_PROD = 4'h1,
      M_EXT = 4'h2,
      M_REG = 4'h4,
      M_DIRECT = 4'h8
   } lddc_method_t;
endpackage

// ===== design/lddc_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the pins change slowly against clk or are quasi-static
`timescale 1ns/1ps
module lddc_sync #(
   parameter int unsigned W = 1
) (
   // clock
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_chk
      $error("lddc_sync: W must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ===== design/lddc_pwm_gen.sv
// internal dimming pwm: a period of STEPS steps, each stepLen clocks long
// assumes duty and stepLen come from the same clock domain
`timescale 1ns/1ps
`include "lddc_consts.svh"
module lddc_pwm_gen #(
   parameter int unsigned STEPS = `LDDC_STEPS
) (
   // clock
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic run,
   input wire logic [15:0] stepLen,
   input wire logic [7:0] duty,
   // timing
   output logic gate,
   output logic stepTick,
   output logic periodEnd
);
   localparam logic [7:0] LAST_STEP = 8'(STEPS - 1);
   logic [15:0] pre_q;
   logic [7:0] step_q;
   logic [15:0] lastPre;

   if (STEPS < 2 || STEPS > 256) begin : g_chk
      $error("lddc_pwm_gen: STEPS must lie in 2..256");
   end

   // a zero step length is served as one clock per step
   assign lastPre = (stepLen == 16'h0000) ? 16'h0000 : stepLen - 16'h0001;
   assign stepTick = run && (pre_q >= lastPre);
   assign periodEnd = stepTick && (step_q == LAST_STEP);
   assign gate = run && (step_q < duty); // see R21

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_q <= 16'h0000;
         step_q <= 8'h00;
      end else if (ce) begin
         // a halt restarts the period, but only on enabled clocks
         if (!run) begin
            pre_q <= 16'h0000;
            step_q <= 8'h00;
         end else if (stepTick) begin
            pre_q <= 16'h0000;
            step_q <= periodEnd ? 8'h00 : step_q + 8'h01; // see R21
         end else begin
            pre_q <= pre_q + 16'h0001;
         end
      end
   end
endmodule

// ===== design/lddc_dimming_ctrl.sv
// led dimming controller: serial register slave, method select, duty
// meter, internal pwm, current scale and enable/pwm-low shutdown.
// assumes all pins are asynchronous to clk; the serial bus is far
// slower than clk.
//
// Contract
// R1 - enable low beyond 30 ms shuts down
// R2 - current scale register 8 bits, resets 255
// R3 - current scale zero turns all channels off
// R4 - current scale writes act immediately while running
// R5 - on level follows scale, off carries nothing
// R6 - all six channels gated together
// R7 - duty register 8 bits, resets to 255
// R8 - duty register zero keeps channels off
// R9 - register pwm on fraction is duty/255
// R10 - control 0x05 selects register-only dimming
// R11 - control register resets to 0x01, product
// R12 - product duty is register times measured duty
// R13 - host holds pwm high for register-only
// R14 - external mode applies measured input duty
// R15 - direct mode copies pwm input edges
// R16 - period comes from external frequency reference
// R17 - control 0x03 selects external-duty dimming
// R18 - 8-bit duty times register, upper byte
// R19 - direct mode strapped by pins at start
// R20 - pwm input low beyond 30.5 ms shuts down; the code skips this timeout in register-only mode
// R21 - period has 255 steps, gate duty steps
// R22 - other control codes leave method unchanged
`timescale 1ns/1ps
`include "lddc_consts.svh"
module lddc_dimming_ctrl import lddc_pkg::*; #(
   parameter int unsigned EN_LOW_CYC =
      (`LDDC_EN_LOW_NS + `LDDC_CLK_NS - 1) / `LDDC_CLK_NS,
   parameter int unsigned PWM_LOW_CYC =
      (`LDDC_PWM_LOW_NS + `LDDC_CLK_NS - 1) / `LDDC_CLK_NS,
   parameter logic [6:0] DEV_ADDR = `LDDC_DEV_ADDR,
   parameter int unsigned CH = 6
) (
   // clock
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // device pins
   input wire logic enablePin,
   input wire logic externalPwmDuty,
   input wire logic dimFreqSetPin,
   input wire logic [15:0] dimStepLen,
   // serial bus lines
   input wire logic busClkIn,
   input wire logic busDatIn,
   output logic busDatOut,
   output logic busDatOe,
   // led channels
   output logic [CH-1:0] ledChannels,
   output logic [7:0] ledLevel,
   output logic shutdown
);
   localparam logic [19:0] EN_LIM = 20'(EN_LOW_CYC);
   localparam logic [19:0] PWM_LIM = 20'(PWM_LOW_CYC);

   if (EN_LOW_CYC < 1 || EN_LOW_CYC >= (1 << 20) ||
       PWM_LOW_CYC < 1 || PWM_LOW_CYC >= (1 << 20) || CH < 1) begin : g_chk
      $error("lddc_dimming_ctrl: counts must fit 20 bits, CH >= 1");
   end

   function automatic logic isCtrlCode(input logic [7:0] v);
      isCtrlCode = (v == `LDDC_CTRL_PROD) || (v == `LDDC_CTRL_EXT) ||
         (v == `LDDC_CTRL_REG);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic enS, pwmS, freqS, sclS, sdaS;
   logic [15:0] stepS;

   lddc_sync #(.W(21)) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d({enablePin, externalPwmDuty, dimFreqSetPin, busClkIn, busDatIn,
         dimStepLen}),
      .q({enS, pwmS, freqS, sclS, sdaS, stepS})
   );

   ////////////////////////////////////////////////////////////////////////
   // direct-mode strap, caught once the synchronisers hold pin levels
   logic [1:0] strapCnt_q;
   logic directMode_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         strapCnt_q <= 2'h0;
         directMode_q <= 1'b0;
      end else if (ce && strapCnt_q != 2'h3) begin
         strapCnt_q <= strapCnt_q + 2'h1;
         if (strapCnt_q == 2'h2) begin
            directMode_q <= freqS && !sclS && !sdaS; // see R19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial bus slave
   logic sclD_q, sdaD_q;
   logic startCond, stopCond, sclRise, sclFall;
   lddc_bus_st_t st_q;
   logic [2:0] bitCnt_q;
   logic [7:0] shift_q, ptr_q, rdByte;
   logic rw_q, havePtr_q, busDatOe_q, addrRise_q;
   logic wrEn;
   logic [7:0] brightDuty_q, ctrl_q, dcScale_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclD_q <= 1'b1;
         sdaD_q <= 1'b1;
      end else if (ce) begin
         sclD_q <= sclS;
         sdaD_q <= sdaS;
      end
   end

   assign startCond = sclS && sclD_q && sdaD_q && !sdaS;
   assign stopCond = sclS && sclD_q && !sdaD_q && sdaS;
   assign sclRise = sclS && !sclD_q;
   assign sclFall = !sclS && sclD_q;

   always_comb begin
      case (ptr_q)
         `LDDC_OFS_DUTY: rdByte = brightDuty_q;
         `LDDC_OFS_CTRL: rdByte = ctrl_q;
         `LDDC_OFS_DCS: rdByte = dcScale_q;
         default: rdByte = `LDDC_RST_READ;
      endcase
   end

   // a register is written on the falling clock edge after its 8th bit
   assign wrEn = ce && !startCond && !stopCond && st_q == S_WBYTE &&
      sclFall && bitCnt_q == 3'h7 && havePtr_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= S_IDLE;
         bitCnt_q <= 3'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         addrRise_q <= 1'b0;
         havePtr_q <= 1'b0;
         busDatOe_q <= 1'b0;
      end else if (ce) begin
         if (startCond) begin
            st_q <= S_ADDR;
            bitCnt_q <= 3'h0;
            addrRise_q <= 1'b0;
            havePtr_q <= 1'b0;
            busDatOe_q <= 1'b0;
         end else if (stopCond) begin
            st_q <= S_IDLE;
            busDatOe_q <= 1'b0;
         end else begin
            case (st_q)
               S_ADDR: begin
                  if (sclRise) begin
                     shift_q <= {shift_q[6:0], sdaS};
                     addrRise_q <= 1'b1;
                  end
                  // the clock fall that closes a start is not a data bit
                  if (sclFall && addrRise_q) begin
                     bitCnt_q <= bitCnt_q + 3'h1;
                     if (bitCnt_q == 3'h7) begin
                        if (shift_q[7:1] == DEV_ADDR) begin
                           st_q <= S_AACK;
                           rw_q <= shift_q[0];
                           busDatOe_q <= 1'b1;
                        end else begin
                           st_q <= S_IDLE;
                        end
                     end
                  end
               end
               S_AACK: begin
                  if (sclFall) begin
                     if (rw_q) begin
                        st_q <= S_RBYTE;
                        shift_q <= rdByte;
                        busDatOe_q <= !rdByte[7];
                     end else begin
                        st_q <= S_WBYTE;
                        busDatOe_q <= 1'b0;
                     end
                  end
               end
               S_WBYTE: begin
                  if (sclRise) begin
                     shift_q <= {shift_q[6:0], sdaS};
                  end
                  if (sclFall) begin
                     bitCnt_q <= bitCnt_q + 3'h1;
                     if (bitCnt_q == 3'h7) begin
                        st_q <= S_WACK;
                        busDatOe_q <= 1'b1;
                        havePtr_q <= 1'b1;
                        ptr_q <= havePtr_q ? ptr_q + 8'h01 : shift_q;
                     end
                  end
               end
               S_WACK: begin
                  if (sclFall) begin
                     st_q <= S_WBYTE;
                     busDatOe_q <= 1'b0;
                  end
               end
               S_RBYTE: begin
                  if (sclFall) begin
                     bitCnt_q <= bitCnt_q + 3'h1;
                     if (bitCnt_q == 3'h7) begin
                        st_q <= S_RACK;
                        busDatOe_q <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                     end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        busDatOe_q <= !shift_q[6];
                     end
                  end
               end
               S_RACK: begin
                  if (sclRise && sdaS) begin
                     st_q <= S_IDLE;
                  end else if (sclFall) begin
                     st_q <= S_RBYTE;
                     shift_q <= rdByte;
                     busDatOe_q <= !rdByte[7];
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         brightDuty_q <= `LDDC_RST_DUTY; // see R7
         dcScale_q <= `LDDC_RST_DCS; // see R2
      end else if (wrEn) begin
         if (ptr_q == `LDDC_OFS_DUTY) begin
            brightDuty_q <= shift_q;
         end
         if (ptr_q == `LDDC_OFS_DCS) begin
            dcScale_q <= shift_q; // see R4
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `LDDC_RST_CTRL; // see R11
      end else if (wrEn && ptr_q == `LDDC_OFS_CTRL && isCtrlCode(shift_q)) begin
         ctrl_q <= shift_q; // see R22
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // method and effective duty
   lddc_method_t method;
   logic [15:0] product;
   logic [7:0] extDuty_q, hiCnt_q, effDuty;
   logic pwmGate, stepTick, periodEnd, halted;

   always_comb begin
      if (directMode_q) begin
         method = M_DIRECT; // see R19
      end else begin
         case (ctrl_q)
            `LDDC_CTRL_REG: method = M_REG; // see R10
            `LDDC_CTRL_EXT: method = M_EXT; // see R17
            default: method = M_PROD;
         endcase
      end
   end

   assign product = brightDuty_q * extDuty_q; // see R12

   always_comb begin
      case (method)
         M_REG: effDuty = brightDuty_q; // see R9
         M_EXT: effDuty = extDuty_q; // see R14
         default: effDuty = product[15:8]; // see R18
      endcase
   end

   // the input is sampled once per step, so 255 samples give its duty
   always_ff @(posedge clk) begin
      if (rst) begin
         hiCnt_q <= 8'h00;
         extDuty_q <= 8'h00;
      end else if (ce && stepTick) begin
         if (periodEnd) begin
            extDuty_q <= hiCnt_q + {7'h00, pwmS}; // see R18
            hiCnt_q <= 8'h00;
         end else begin
            hiCnt_q <= hiCnt_q + {7'h00, pwmS};
         end
      end
   end

   lddc_pwm_gen #(.STEPS(`LDDC_STEPS)) u_pwm (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .run(!halted),
      .stepLen(stepS), // see R16
      .duty(effDuty),
      .gate(pwmGate),
      .stepTick(stepTick),
      .periodEnd(periodEnd)
   );

   ////////////////////////////////////////////////////////////////////////
   // shutdown timers; each clears as soon as its pin returns high
   logic [19:0] enLowCnt_q, pwmLowCnt_q;
   logic enShut_q, pwmShut_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         enLowCnt_q <= 20'h00000;
         enShut_q <= 1'b0;
      end else if (ce) begin
         if (enS) begin
            enLowCnt_q <= 20'h00000;
            enShut_q <= 1'b0;
         end else if (enLowCnt_q != EN_LIM) begin
            enLowCnt_q <= enLowCnt_q + 20'h00001;
         end else begin
            enShut_q <= 1'b1; // see R1
         end
      end
   end

   // register-only dimming ignores the input, so it cannot time out there
   always_ff @(posedge clk) begin
      if (rst) begin
         pwmLowCnt_q <= 20'h00000;
         pwmShut_q <= 1'b0;
      end else if (ce) begin
         if (pwmS || method == M_REG) begin
            pwmLowCnt_q <= 20'h00000;
            pwmShut_q <= 1'b0;
         end else if (pwmLowCnt_q != PWM_LIM) begin
            pwmLowCnt_q <= pwmLowCnt_q + 20'h00001;
         end else begin
            pwmShut_q <= 1'b1; // see R20
         end
      end
   end

   assign halted = enShut_q || pwmShut_q;

   ////////////////////////////////////////////////////////////////////////
   // channel outputs
   logic chanOn;
   logic [CH-1:0] ledChannels_q;
   logic [7:0] ledLevel_q;
   logic shutdown_q, busDatOut_q;

   assign chanOn = !halted && dcScale_q != 8'h00 && // see R3
      (method == M_DIRECT ? pwmS : pwmGate); // see R15

   always_ff @(posedge clk) begin
      if (rst) begin
         ledChannels_q <= '0;
         ledLevel_q <= 8'h00;
         shutdown_q <= 1'b0;
         busDatOut_q <= 1'b0;
      end else if (ce) begin
         ledChannels_q <= {CH{chanOn}}; // see R6
         ledLevel_q <= chanOn ? dcScale_q : 8'h00; // see R5
         shutdown_q <= halted;
         busDatOut_q <= 1'b0;
      end
   end

   assign ledChannels = ledChannels_q;
   assign ledLevel = ledLevel_q;
   assign shutdown = shutdown_q;
   assign busDatOut = busDatOut_q;
   assign busDatOe = busDatOe_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_rst_vals;
      $past(rst) |-> dcScale_q == `LDDC_RST_DCS &&
         brightDuty_q == `LDDC_RST_DUTY && ctrl_q == `LDDC_RST_CTRL;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else // see R2
      $error("register reset values wrong");

   property p_dc_zero;
      ce && dcScale_q == 8'h00 |=> ledChannels_q == '0;
   endproperty
   a_dc_zero: assert property (p_dc_zero) else // see R3
      $error("channels on with zero current scale");

   property p_level_on;
      ledChannels_q[0] |-> ledLevel_q == $past(dcScale_q) && !shutdown_q;
   endproperty
   a_level_on: assert property (p_level_on) else // see R5
      $error("on level differs from current scale");

   property p_level_off;
      !ledChannels_q[0] |-> ledLevel_q == 8'h00;
   endproperty
   a_level_off: assert property (p_level_off) else // see R5
      $error("current during off portion");

   property p_together;
      ledChannels_q == {CH{ledChannels_q[0]}};
   endproperty
   a_together: assert property (p_together) else // see R6
      $error("channels not gated together");

   property p_duty_zero;
      ce && method == M_REG && brightDuty_q == 8'h00 |=> !ledChannels_q[0];
   endproperty
   a_duty_zero: assert property (p_duty_zero) else // see R8
      $error("channel on with zero duty");

   property p_en_shut;
      $rose(enShut_q) |-> $past(enLowCnt_q) == EN_LIM && !$past(enS);
   endproperty
   a_en_shut: assert property (p_en_shut) else // see R1
      $error("enable shutdown before the low time ran out");

   property p_bad_ctrl;
      wrEn && ptr_q == `LDDC_OFS_CTRL && !isCtrlCode(shift_q) |=>
         $stable(ctrl_q);
   endproperty
   a_bad_ctrl: assert property (p_bad_ctrl) else // see R22
      $error("undefined control code changed the method");

   property p_direct;
      ce && method == M_DIRECT && !halted && dcScale_q != 8'h00 |=>
         ledChannels_q[0] == $past(pwmS);
   endproperty
   a_direct: assert property (p_direct) else // see R15
      $error("direct mode does not follow the pwm input");

   c_write: cover property (wrEn ##1 st_q == S_WACK);
   c_read: cover property (st_q == S_RACK ##[1:400] st_q == S_RBYTE);
   c_shut: cover property ($rose(shutdown_q));
   c_period: cover property (periodEnd && extDuty_q != 8'h00);
endmodule

// ===== test/lddc_host_model.sv
// far-side model: serial bus master on an open-drain data line, plus the
// external pwm source; tasks are started just after a clk edge
`timescale 1ns/1ps
`include "lddc_consts.svh"
module lddc_host_model #(
   parameter logic [6:0] ADDR = `LDDC_DEV_ADDR
) (
   // serial bus lines
   output logic busClk,
   output logic busDatRel,
   input wire logic busDat,
   // pwm source
   output logic extPwm
);
   // quarter bit, a multiple of the clk period so changes stay off edge
   localparam int Q = 100;
   // pwm high and low times in clk periods; a new setting acts at once
   int pwmHi = 0;
   int pwmLo = 0;
   int pwmPh = 0;
   initial begin
      busClk = 1'b1;
      busDatRel = 1'b1;
      extPwm = 1'b1;
      #1;
      forever begin
         // zero low time holds the input high for full duty
         extPwm = (pwmLo == 0) || (pwmPh < pwmHi);
         pwmPh = (pwmPh + 1 >= pwmHi + pwmLo) ? 0 : pwmPh + 1;
         #50;
      end
   end
   task automatic pwm(input int hi, input int lo);
      pwmHi = hi;
      pwmLo = lo;
      pwmPh = 0;
   endtask
   task automatic strap(input logic lvl);
      busClk = lvl;
      busDatRel = lvl;
   endtask
   task automatic bitIo(input logic b, output logic r);
      #Q busDatRel = b;
      #Q busClk = 1'b1;
      #Q r = busDat;
      #Q busClk = 1'b0;
   endtask
   task automatic byteIo(input logic [7:0] w, input logic ackIn,
         output logic [7:0] r, output logic ackOut);
      for (int i = 7; i >= 0; i--) bitIo(w[i], r[i]);
      bitIo(ackIn, ackOut);
   endtask
   task automatic sStart();
      #Q busDatRel = 1'b1;
      #Q busClk = 1'b1;
      #Q busDatRel = 1'b0;
      #Q busClk = 1'b0;
   endtask
   task automatic sStop();
      #Q busDatRel = 1'b0;
      #Q busClk = 1'b1;
      #Q busDatRel = 1'b1;
      #Q;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d,
         output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      sStart();
      byteIo({ADDR, 1'b0}, 1'b1, r, a0);
      byteIo(p, 1'b1, r, a1);
      byteIo(d, 1'b1, r, a2);
      sStop();
      ok = ~(a0 | a1 | a2);
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      sStart();
      byteIo({ADDR, 1'b0}, 1'b1, r, a);
      byteIo(p, 1'b1, r, a);
      sStart();
      byteIo({ADDR, 1'b1}, 1'b1, r, a);
      // nack ends the read
      byteIo(8'hFF, 1'b1, d, a);
      sStop();
   endtask
endmodule

// ===== test/testbench.sv
// self-checking bench: register access over the serial bus, duty counted
// at the channel outputs; assumes a 20 MHz clk and shortened timeouts
`timescale 1ns/1ps
module testbench;
   import lddc_pkg::*;
   logic clk, rst, ce, enablePin, dimFreqSetPin;
   logic busClk, busDatRel, extPwm, busDatOe, shutdown;
   logic [5:0] ledChannels;
   logic [7:0] ledLevel;
   int err_count = 0;
   int n_checks = 0;
   // open-drain data line with pull-up
   wire busDat = busDatRel & ~busDatOe;
   lddc_host_model i_lddc_host_model (.busClk(busClk),
      .busDatRel(busDatRel), .busDat(busDat), .extPwm(extPwm));
   lddc_dimming_ctrl #(.EN_LOW_CYC(50), .PWM_LOW_CYC(60))
   i_lddc_dimming_ctrl (.clk(clk), .rst(rst), .ce(ce),
      .enablePin(enablePin), .externalPwmDuty(extPwm),
      .dimFreqSetPin(dimFreqSetPin), .dimStepLen(16'h0001),
      .busClkIn(busClk), .busDatIn(busDat), .busDatOut(),
      .busDatOe(busDatOe), .ledChannels(ledChannels),
      .ledLevel(ledLevel), .shutdown(shutdown));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic ok;
      cyc(1);
      i_lddc_host_model.wr(p, d, ok);
      check(ok, 1'b1);
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] d;
      cyc(1);
      i_lddc_host_model.rd(p, d);
      check(d, exp);
   endtask
   // settle three periods, then count on-cycles over one 255-step period
   task automatic meas(input logic [7:0] lvl, input logic [8:0] expOn);
      int on, bad;
      on = 0;
      bad = 0;
      cyc(765);
      repeat (255) begin
         cyc(1);
         if (ledChannels === 6'h3F) begin
            on++;
            if (ledLevel !== lvl) bad++;
         end else if (ledChannels !== 6'h00 || ledLevel !== 8'h00) bad++;
      end
      check(on, expOn);
      check(bad, 0);
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      enablePin = 1'b1;
      dimFreqSetPin = 1'b0;
      cyc(5);
      rst = 1'b0;
      cyc(5);
      rd(8'h00, 8'hFF);
      rd(8'h01, 8'h01);
      rd(8'h07, 8'hFF);
      rd(8'h03, 8'h00);
      $display("test reset values done");
      meas(8'hFF, 254);
      i_lddc_host_model.pwm(34, 17);
      meas(8'hFF, 169);
      $display("test product default done");
      wr(8'h01, 8'h05);
      wr(8'h00, 8'h80);
      i_lddc_host_model.pwm(0, 1);
      meas(8'hFF, 128);
      check(shutdown, 1'b0);
      wr(8'h00, 8'h00);
      meas(8'hFF, 0);
      $display("test register mode done");
      i_lddc_host_model.pwm(34, 17);
      wr(8'h00, 8'h80);
      wr(8'h01, 8'h03);
      meas(8'hFF, 170);
      wr(8'h01, 8'h07);
      meas(8'hFF, 170);
      $display("test external mode done");
      wr(8'h07, 8'h40);
      meas(8'h40, 170);
      wr(8'h07, 8'h00);
      meas(8'h00, 0);
      wr(8'h07, 8'hFF);
      wr(8'h01, 8'h01);
      meas(8'hFF, 85);
      $display("test current scale done");
      enablePin = 1'b0;
      cyc(40);
      enablePin = 1'b1;
      cyc(10);
      check(shutdown, 1'b0);
      enablePin = 1'b0;
      cyc(60);
      check(shutdown, 1'b1);
      check(ledChannels, 6'h00);
      enablePin = 1'b1;
      cyc(10);
      check(shutdown, 1'b0);
      rd(8'h00, 8'h80);
      // with the clock enable low the low-time counter must not advance
      ce = 1'b0;
      i_lddc_host_model.pwm(0, 1);
      cyc(80);
      check(shutdown, 1'b0);
      ce = 1'b1;
      cyc(40);
      check(shutdown, 1'b0);
      cyc(40);
      check(shutdown, 1'b1);
      i_lddc_host_model.pwm(34, 17);
      cyc(10);
      check(shutdown, 1'b0);
      $display("test shutdown done");
      dimFreqSetPin = 1'b1;
      i_lddc_host_model.strap(1'b0);
      rst = 1'b1;
      cyc(5);
      rst = 1'b0;
      i_lddc_host_model.pwm(5, 12);
      meas(8'hFF, 75);
      $display("test direct mode done");
      end_sim();
   end
   initial begin
      #2000000;
      err_count++;
      end_sim();
   end
endmodule
